// >>> pkg/gain_apply_if.sv
// Carries one side's pending gain and its apply events to the gain holder.
// Assumes a single clock domain shared by both ends.
`default_nettype none
interface gain_apply_if;
    import pga_ctrl_pkg::*;
    logic update;
    logic zc_gate;
    logic zero_cross;
    logic timeout_tick;
    logic [GAIN_W-1:0] target;
    logic [GAIN_W-1:0] applied;
    logic armed;
    modport ctrl (output update, output zc_gate, output zero_cross, output timeout_tick,
                  output target, input applied, input armed);
    modport side (input update, input zc_gate, input zero_cross, input timeout_tick,
                  input target, output applied, output armed);
endinterface
`default_nettype wire

// >>> pkg/pga_ctrl_pkg.sv
// Constants shared by the input amplifier gain control block.
// Assumes a 32-bit register bus with byte addresses, one word per register.
`default_nettype none
package pga_ctrl_pkg;
    // ==========================================
    // Bus and register indices (byte address = 4 * index)
    localparam int ADDR_W = 10;
    localparam int IDX_W = ADDR_W - 2;
    localparam logic [IDX_W-1:0] IDX_LEFT_VOL = 8'h00;
    localparam logic [IDX_W-1:0] IDX_RIGHT_VOL = 8'h01;
    localparam logic [IDX_W-1:0] IDX_TIMEOUT_CTRL = 8'h02;
    localparam logic [IDX_W-1:0] IDX_APPLIED = 8'h03;
    localparam logic [IDX_W-1:0] IDX_POWER_ONE = 8'h19;
    localparam logic [IDX_W-1:0] IDX_LEFT_AMP = 8'h25;
    localparam logic [IDX_W-1:0] IDX_RIGHT_AMP = 8'h26;
    // ==========================================
    // Field positions
    localparam int VOL_UPDATE_BIT = 8;
    localparam int VOL_SILENCE_BIT = 7;
    localparam int VOL_ZC_BIT = 6;
    localparam int GAIN_W = 6;
    localparam int PWR_LEFT_BIT = 5;
    localparam int PWR_RIGHT_BIT = 4;
    localparam int AMP_ON_BIT = 4;
    localparam int AMP_CTL_W = 5;
    localparam int TO_ON_BIT = 0;
    localparam int TO_DIV_LSB = 1;
    localparam int TO_DIV_W = 3;
    localparam int APPLIED_RIGHT_LSB = 8;
    localparam int APPLIED_SILENCE_LSB = 16;
    localparam int APPLIED_ARMED_LSB = 18;
    localparam int APPLIED_ACTIVE_LSB = 20;
    // ==========================================
    // Reset values and timing
    localparam logic [GAIN_W-1:0] GAIN_ZERO_DB = 6'h1F;
    localparam logic [7:0] VOL_RST = 8'h9F;
    localparam logic [AMP_CTL_W-1:0] AMP_CTL_RST = 5'h08;
    localparam int GAIN_STEP_MILLI_DB = 750;
    localparam int TO_BASE_CYCLES_DFLT = 1024;
endpackage
`default_nettype wire

// >>> src/gain_apply.sv
// Holds one side's gain in effect; applies a pending code at once or on zero cross / timeout.
// Assumes update is a one-cycle strobe and target is valid with it.
`default_nettype none
module gain_apply
    import pga_ctrl_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Control side
    gain_apply_if.side gi
);
    typedef struct packed {
        logic [GAIN_W-1:0] applied;
        logic [GAIN_W-1:0] target;
        logic armed;
    } state_t;
    state_t st_reg, st_next;
    always_comb begin
        st_next = st_reg;
        if (gi.update) begin
            st_next.target = gi.target;
            st_next.armed = gi.zc_gate; // R10
            if (!gi.zc_gate) begin
                st_next.applied = gi.target; // R13
            end
        end else if (st_reg.armed && (gi.zero_cross || gi.timeout_tick || !gi.zc_gate)) begin
            // Gate dropped while waiting counts as apply-now
            st_next.applied = st_reg.target; // R11
            st_next.armed = 1'b0;
        end
    end
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st_reg <= '{applied: GAIN_ZERO_DB, target: GAIN_ZERO_DB, armed: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end
    assign gi.applied = st_reg.applied; // R08
    assign gi.armed = st_reg.armed;
    // ==========================================
    // Checks
    hold_pending_a: assert property (@(posedge clk_sys) disable iff (!nrst) // R12
        !gi.update && !st_reg.armed |=> $stable(gi.applied))
        else $error("gain changed with no update pending");
    apply_now_a: assert property (@(posedge clk_sys) disable iff (!nrst) // R13
        gi.update && !gi.zc_gate |=> gi.applied == $past(gi.target) && !gi.armed)
        else $error("immediate gain update missed");
    zc_apply_a: assert property (@(posedge clk_sys) disable iff (!nrst) // R10
        gi.armed && gi.zc_gate && gi.zero_cross && !gi.update
        |=> gi.applied == $past(st_reg.target) && !gi.armed)
        else $error("zero cross did not apply held gain");
    timeout_apply_a: assert property (@(posedge clk_sys) disable iff (!nrst) // R11
        gi.armed && gi.timeout_tick && !gi.update |=> gi.applied == $past(st_reg.target) && !gi.armed)
        else $error("timeout did not apply held gain");
endmodule
`default_nettype wire

// >>> src/input_pga_gain_control.sv
// Input amplifier gain control register bank with an Avalon-MM slave port.
// Assumes byte addresses, one aligned 32-bit word per register, one clock domain.
// Operation
// [R01] Left path power bit enables left amplifier and left mixer together; off at reset.
// [R02] Right path power bit enables right amplifier and right mixer together; off at reset.
// [R03] Left amplifier active when its own enable or left path power is set.
// [R04] Right amplifier active when its own enable or right path power is set.
// [R05] Software enables midpoint reference and bias before using either amplifier.
// [R06] Left control bits 3..0 connect left pins 1..4; pin 1 only after reset.
// [R07] Right control bits 3..0 connect right pins 1..4; pin 1 only after reset.
// [R08] Six-bit gain code is linear, 0.75 dB steps, code 31 is 0 dB.
// [R09] Volume bit 7 mutes its side; sides independent; muted after reset.
// [R10] Zero-cross gate off applies gain at once; on waits for zero crossing.
// [R11] With gate on, a timeout tick applies a held gain change.
// [R12] Volume write without update bit only stores the pending gain; clearing the zero-cross bit while armed also applies the held gain.
// [R13] Update bit on either volume register applies both sides' gains together.
// [R14] Mute bits of both sides take effect only on an update bit write.
// [R15] Software keeps level-control and converter enable ordering to avoid stuck gain.
// [R16] Update bit is a write strobe only and reads back as zero.
`default_nettype none
module input_pga_gain_control
    import pga_ctrl_pkg::*;
#(
    parameter int TO_BASE_CYCLES = TO_BASE_CYCLES_DFLT
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Avalon-MM slave
    input wire logic [ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Zero crossing pulses from the analogue paths
    input wire logic left_zero_cross,
    input wire logic right_zero_cross,
    // Amplifier and mixer controls
    output logic left_amp_active,
    output logic right_amp_active,
    output logic left_mixer_on,
    output logic right_mixer_on,
    output logic [3:0] left_pin_select,
    output logic [3:0] right_pin_select,
    output logic [GAIN_W-1:0] left_gain_code,
    output logic [GAIN_W-1:0] right_gain_code,
    output logic left_amp_silence,
    output logic right_amp_silence
);
    // ==========================================
    // State
    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic [7:0] left_vol;
        logic [7:0] right_vol;
        logic left_path_power;
        logic right_path_power;
        logic [AMP_CTL_W-1:0] left_amp_ctl;
        logic [AMP_CTL_W-1:0] right_amp_ctl;
        logic timeout_clock_on;
        logic [TO_DIV_W-1:0] timeout_divider;
        logic [1:0] silence;
        logic [1:0] amp_active;
        logic [1:0] mixer_on;
    } state_t;

    localparam state_t ST_RST = '{
        ack: 1'b0, rdata: 32'h0, left_vol: VOL_RST, right_vol: VOL_RST,
        left_path_power: 1'b0, right_path_power: 1'b0,
        left_amp_ctl: AMP_CTL_RST, right_amp_ctl: AMP_CTL_RST,
        timeout_clock_on: 1'b0, timeout_divider: '0,
        silence: 2'h3, amp_active: 2'h0, mixer_on: 2'h0};

    state_t st_reg, st_next;
    logic [IDX_W-1:0] idx;
    logic [31:0] rd_image;
    logic [31:0] wr_value;
    logic acc_write;
    logic update;
    logic timeout_tick;

    gain_apply_if left_if ();
    gain_apply_if right_if ();

    // ==========================================
    // Helpers
    function automatic logic is_volume(input logic [IDX_W-1:0] i);
        return (i == IDX_LEFT_VOL) || (i == IDX_RIGHT_VOL);
    endfunction

    function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] wd,
                                               input logic [3:0] be);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        return (wd & m) | (old & ~m);
    endfunction

    // ==========================================
    // Register readback
    assign idx = address[ADDR_W-1:2];

    always_comb begin
        rd_image = 32'h0;
        case (idx)
            IDX_LEFT_VOL: begin
                rd_image[7:0] = st_reg.left_vol; // R16
            end
            IDX_RIGHT_VOL: begin
                rd_image[7:0] = st_reg.right_vol; // R16
            end
            IDX_TIMEOUT_CTRL: begin
                rd_image[TO_ON_BIT] = st_reg.timeout_clock_on;
                rd_image[TO_DIV_LSB +: TO_DIV_W] = st_reg.timeout_divider;
            end
            IDX_APPLIED: begin
                rd_image[GAIN_W-1:0] = left_if.applied;
                rd_image[APPLIED_RIGHT_LSB +: GAIN_W] = right_if.applied;
                rd_image[APPLIED_SILENCE_LSB +: 2] = st_reg.silence;
                rd_image[APPLIED_ARMED_LSB +: 2] = {right_if.armed, left_if.armed};
                rd_image[APPLIED_ACTIVE_LSB +: 2] = st_reg.amp_active;
            end
            IDX_POWER_ONE: begin
                rd_image[PWR_LEFT_BIT] = st_reg.left_path_power;
                rd_image[PWR_RIGHT_BIT] = st_reg.right_path_power;
            end
            IDX_LEFT_AMP: begin
                rd_image[AMP_CTL_W-1:0] = st_reg.left_amp_ctl;
            end
            IDX_RIGHT_AMP: begin
                rd_image[AMP_CTL_W-1:0] = st_reg.right_amp_ctl;
            end
            default: begin
                rd_image = 32'h0;
            end
        endcase
    end

    // ==========================================
    // Next state
    // One wait cycle per access keeps readdata a clean register output.
    assign acc_write = write && st_reg.ack;
    assign wr_value = lane_merge(rd_image, writedata, byteenable);
    assign update = acc_write && is_volume(idx) && byteenable[1] && writedata[VOL_UPDATE_BIT]; // R16

    always_comb begin
        st_next = st_reg;
        st_next.ack = (read || write) && !st_reg.ack;
        if (read && !st_reg.ack) begin
            st_next.rdata = rd_image;
        end
        if (acc_write) begin
            case (idx)
                IDX_LEFT_VOL: begin
                    st_next.left_vol = wr_value[7:0]; // R12
                end
                IDX_RIGHT_VOL: begin
                    st_next.right_vol = wr_value[7:0]; // R12
                end
                IDX_TIMEOUT_CTRL: begin
                    st_next.timeout_clock_on = wr_value[TO_ON_BIT];
                    st_next.timeout_divider = wr_value[TO_DIV_LSB +: TO_DIV_W];
                end
                IDX_POWER_ONE: begin
                    st_next.left_path_power = wr_value[PWR_LEFT_BIT];
                    st_next.right_path_power = wr_value[PWR_RIGHT_BIT];
                end
                IDX_LEFT_AMP: begin
                    st_next.left_amp_ctl = wr_value[AMP_CTL_W-1:0]; // R06
                end
                IDX_RIGHT_AMP: begin
                    st_next.right_amp_ctl = wr_value[AMP_CTL_W-1:0]; // R07
                end
                default: begin
                    st_next.ack = st_next.ack;
                end
            endcase
        end
        if (update) begin
            st_next.silence = {st_next.right_vol[VOL_SILENCE_BIT], st_next.left_vol[VOL_SILENCE_BIT]}; // R14
        end
        st_next.amp_active[0] = st_next.left_amp_ctl[AMP_ON_BIT] || st_next.left_path_power; // R03
        st_next.amp_active[1] = st_next.right_amp_ctl[AMP_ON_BIT] || st_next.right_path_power; // R04
        st_next.mixer_on = {st_next.right_path_power, st_next.left_path_power}; // R01 R02
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st_reg <= ST_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // ==========================================
    // Gain holders and timeout
    // Both sides see the same strobe, so with both zero-cross gates off they switch together.
    assign left_if.update = update; // R13
    assign left_if.zc_gate = st_next.left_vol[VOL_ZC_BIT];
    assign left_if.zero_cross = left_zero_cross;
    assign left_if.timeout_tick = timeout_tick;
    assign left_if.target = st_next.left_vol[GAIN_W-1:0];
    assign right_if.update = update; // R13
    assign right_if.zc_gate = st_next.right_vol[VOL_ZC_BIT];
    assign right_if.zero_cross = right_zero_cross;
    assign right_if.timeout_tick = timeout_tick;
    assign right_if.target = st_next.right_vol[GAIN_W-1:0];

    gain_apply u_left_gain (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .gi(left_if.side)
    );

    gain_apply u_right_gain (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .gi(right_if.side)
    );

    // Without the timeout clock a gated change waits for a real crossing
    timeout_ticker #(
        .BASE_CYCLES(TO_BASE_CYCLES)
    ) u_ticker (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .enable(st_reg.timeout_clock_on),
        .divider(st_reg.timeout_divider),
        .tick(timeout_tick) // R11
    );

    // ==========================================
    // Outputs
    assign waitrequest = (read || write) && !st_reg.ack;
    assign readdata = st_reg.rdata;
    assign left_amp_active = st_reg.amp_active[0];
    assign right_amp_active = st_reg.amp_active[1];
    assign left_mixer_on = st_reg.mixer_on[0];
    assign right_mixer_on = st_reg.mixer_on[1];
    assign left_pin_select = st_reg.left_amp_ctl[3:0];
    assign right_pin_select = st_reg.right_amp_ctl[3:0];
    assign left_gain_code = left_if.applied; // R08
    assign right_gain_code = right_if.applied; // R08
    assign left_amp_silence = st_reg.silence[0]; // R09
    assign right_amp_silence = st_reg.silence[1]; // R09

    // ==========================================
    // Checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);

    left_path_on_a: assert property ( // R01
        acc_write && idx == IDX_POWER_ONE && byteenable[0]
        |=> left_mixer_on == $past(writedata[PWR_LEFT_BIT]) && (!left_mixer_on || left_amp_active))
        else $error("left path power did not steer mixer and amplifier");
    right_path_on_a: assert property ( // R02
        acc_write && idx == IDX_POWER_ONE && byteenable[0]
        |=> right_mixer_on == $past(writedata[PWR_RIGHT_BIT]) && (!right_mixer_on || right_amp_active))
        else $error("right path power did not steer mixer and amplifier");
    left_amp_or_a: assert property ( // R03
        left_amp_active == (st_reg.left_amp_ctl[AMP_ON_BIT] || left_mixer_on))
        else $error("left amplifier enable is not the OR of its sources");
    right_amp_or_a: assert property ( // R04
        right_amp_active == (st_reg.right_amp_ctl[AMP_ON_BIT] || right_mixer_on))
        else $error("right amplifier enable is not the OR of its sources");
    left_pin_write_a: assert property ( // R06
        acc_write && idx == IDX_LEFT_AMP && byteenable[0]
        |=> left_pin_select == $past(writedata[3:0]))
        else $error("left pin select not written");
    right_pin_write_a: assert property ( // R07
        acc_write && idx == IDX_RIGHT_AMP && byteenable[0]
        |=> right_pin_select == $past(writedata[3:0]))
        else $error("right pin select not written");
    mute_update_a: assert property ( // R14
        update && idx == IDX_LEFT_VOL && byteenable[0]
        |=> left_amp_silence == $past(writedata[VOL_SILENCE_BIT]))
        else $error("mute did not follow update write");
    mute_hold_a: assert property ( // R14
        !update |=> $stable(left_amp_silence) && $stable(right_amp_silence))
        else $error("mute changed without update");
    both_sides_a: assert property ( // R13
        update && !left_if.zc_gate && !right_if.zc_gate
        |=> left_gain_code == $past(left_if.target) && right_gain_code == $past(right_if.target))
        else $error("sides not updated together");
    strobe_reads_zero_a: assert property ( // R16
        read && !waitrequest && is_volume(idx) |-> readdata[VOL_UPDATE_BIT] == 1'b0)
        else $error("update bit read back nonzero");
endmodule
`default_nettype wire

// >>> src/timeout_ticker.sv
// Timeout tick generator: one pulse every (divider+1)*BASE_CYCLES clocks.
// Assumes enable and divider are static register bits.
`default_nettype none
module timeout_ticker
    import pga_ctrl_pkg::*;
#(
    parameter int BASE_CYCLES = TO_BASE_CYCLES_DFLT
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Control
    input wire logic enable,
    input wire logic [TO_DIV_W-1:0] divider,
    output logic tick
);
    typedef struct packed {
        logic [23:0] count;
        logic tick;
    } state_t;
    state_t st_reg, st_next;
    logic [23:0] period;
    always_comb begin
        period = 24'((32'(divider) + 32'd1) * 32'(BASE_CYCLES));
        st_next = st_reg;
        st_next.tick = 1'b0;
        if (!enable) begin
            st_next.count = 24'h0;
        end else if (st_reg.count >= period - 24'h1) begin
            st_next.count = 24'h0;
            st_next.tick = 1'b1;
        end else begin
            st_next.count = st_reg.count + 24'h1;
        end
    end
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
    assign tick = st_reg.tick;
endmodule
`default_nettype wire

// >>> verif/input_pga_gain_control_tb.sv
// Self-checking bench for the input amplifier gain control register bank.
// Assumes the design package and modules are compiled first; bench drives all ports itself.
`default_nettype none
module input_pga_gain_control_tb
    import pga_ctrl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // Design connections
    logic clk_sys, nrst, read, write, left_zero_cross, right_zero_cross, waitrequest, snap;
    logic [ADDR_W-1:0] address;
    logic [31:0] writedata, readdata, r;
    logic [3:0] byteenable, left_pin_select, right_pin_select;
    logic [3:0] be = 4'hF;
    logic left_amp_active, right_amp_active, left_mixer_on, right_mixer_on;
    logic left_amp_silence, right_amp_silence;
    logic [GAIN_W-1:0] left_gain_code, right_gain_code;
    logic [25:0] port_vec;
    logic [31:0] q_rd[$];
    logic [25:0] q_port[$];
    int checked = 0;
    int n_mismatch = 0;
    int cyc = 0;
    int seed = 82;
    // Bench copy of what the outputs should be
    logic [5:0] pwr, lg, rg;
    logic [4:0] lamp, ramp;
    logic ls, rs;

    // Short timeout base keeps the held-gain wait to a few cycles
    input_pga_gain_control #(.TO_BASE_CYCLES(4)) DUT (
        .clk_sys(clk_sys), .nrst(nrst), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
        .left_zero_cross(left_zero_cross), .right_zero_cross(right_zero_cross),
        .left_amp_active(left_amp_active), .right_amp_active(right_amp_active),
        .left_mixer_on(left_mixer_on), .right_mixer_on(right_mixer_on),
        .left_pin_select(left_pin_select), .right_pin_select(right_pin_select),
        .left_gain_code(left_gain_code), .right_gain_code(right_gain_code),
        .left_amp_silence(left_amp_silence), .right_amp_silence(right_amp_silence));

    assign port_vec = {left_amp_active, right_amp_active, left_mixer_on, right_mixer_on, left_pin_select,
                       right_pin_select, left_gain_code, right_gain_code, left_amp_silence, right_amp_silence};

    // ==========================================
    // Clock, timeout, closing report
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    task automatic test_done();
        $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            test_done();
        end
    end

    // ==========================================
    // Compare tasks and watcher
    task automatic cmp_rd(input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH readdata exp=%h got=%h", e, g);
        end
    endtask

    task automatic cmp_port(input logic [25:0] e, input logic [25:0] g);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH port_vec exp=%h got=%h", e, g);
        end
    endtask

    // Mid-cycle look: at the taking edge itself the state update races this process
    always @(negedge clk_sys) begin
        if (read === 1'b1 && waitrequest === 1'b0) cmp_rd(q_rd.size() ? q_rd.pop_front() : 32'hX, readdata);
    end

    always @(negedge clk_sys) begin
        if (snap === 1'b1) cmp_port(q_port.size() ? q_port.pop_front() : 26'hX, port_vec);
    end

    // ==========================================
    // Avalon-MM master and note-taking
    task automatic bus(input logic wr, input logic [IDX_W-1:0] idx, input logic [31:0] d);
        logic w;
        @(posedge clk_sys);
        address <= {idx, 2'b00};
        writedata <= d;
        byteenable <= be;
        read <= ~wr;
        write <= wr;
        do begin
            @(negedge clk_sys);
            w = waitrequest;
            @(posedge clk_sys);
        end while (w !== 1'b0);
        read <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic wr_reg(input logic [IDX_W-1:0] idx, input logic [31:0] d);
        bus(1'b1, idx, d);
    endtask

    task automatic rd_chk(input logic [IDX_W-1:0] idx, input logic [31:0] e);
        q_rd.push_back(e);
        bus(1'b0, idx, 32'h0000_0000);
    endtask

    task automatic chk_port();
        q_port.push_back({lamp[4] | pwr[5], ramp[4] | pwr[4], pwr[5], pwr[4], lamp[3:0], ramp[3:0], lg, rg, ls, rs});
        @(posedge clk_sys);
        snap <= 1'b1;
        @(posedge clk_sys);
        snap <= 1'b0;
    endtask

    // ==========================================
    // Main sequence
    initial begin
        nrst = 1'b0;
        read = 1'b0;
        write = 1'b0;
        address = '0;
        writedata = '0;
        byteenable = 4'h0;
        left_zero_cross = 1'b0;
        right_zero_cross = 1'b0;
        snap = 1'b0;
        repeat (8) @(posedge clk_sys);
        nrst <= 1'b1;
        pwr = 6'h00;
        lamp = 5'h08;
        ramp = 5'h08;
        lg = 6'h1F;
        rg = 6'h1F;
        ls = 1'b1;
        rs = 1'b1;
        chk_port();
        rd_chk(IDX_LEFT_VOL, 32'h0000_009F);
        rd_chk(IDX_RIGHT_VOL, 32'h0000_009F);
        rd_chk(IDX_POWER_ONE, 32'h0000_0000);
        rd_chk(IDX_LEFT_AMP, 32'h0000_0008);
        rd_chk(IDX_RIGHT_AMP, 32'h0000_0008);
        rd_chk(IDX_APPLIED, 32'h0003_1F1F);
        // Unmapped word swallows writes and reads zero
        wr_reg(8'h40, 32'hFFFF_FFFF);
        rd_chk(8'h40, 32'h0000_0000);
        // Reference, bias and level-control ordering live outside; the bench plays compliant software
        // Every pairing of path power and own enable, both sides
        for (int i = 0; i < 4; i++) begin
            r = $random(seed);
            pwr = {i[0], i[1], 4'h0};
            lamp = {i[1], r[3:0]};
            ramp = {i[0], r[7:4]};
            wr_reg(IDX_POWER_ONE, {26'h0, pwr});
            wr_reg(IDX_LEFT_AMP, {27'h0, lamp});
            wr_reg(IDX_RIGHT_AMP, {27'h0, ramp});
            chk_port();
            rd_chk(IDX_RIGHT_AMP, {27'h0, ramp});
        end
        // Pending gain stays out of effect until the strobe
        r = $random(seed);
        wr_reg(IDX_LEFT_VOL, {24'h0, 2'b00, r[5:0]});
        chk_port();
        rd_chk(IDX_LEFT_VOL, {24'h0, 2'b00, r[5:0]});
        wr_reg(IDX_RIGHT_VOL, {23'h0, 3'b100, r[11:6]});
        lg = r[5:0];
        rg = r[11:6];
        ls = 1'b0;
        rs = 1'b0;
        chk_port();
        rd_chk(IDX_RIGHT_VOL, {26'h0, r[11:6]});
        rd_chk(IDX_APPLIED, {10'h0, ramp[4] | pwr[4], lamp[4] | pwr[5], 6'h00, rg, 2'b00, lg});
        // Zero-cross gate holds the gain; mute still follows the strobe
        wr_reg(IDX_LEFT_VOL, {23'h0, 3'b111, ~lg});
        ls = 1'b1;
        chk_port();
        @(posedge clk_sys);
        left_zero_cross <= 1'b1;
        @(posedge clk_sys);
        left_zero_cross <= 1'b0;
        lg = ~lg;
        chk_port();
        // No crossing on the right: timeout releases the held gain
        wr_reg(IDX_RIGHT_VOL, {23'h0, 3'b101, ~rg});
        chk_port();
        wr_reg(IDX_TIMEOUT_CTRL, 32'h0000_0001);
        rg = ~rg;
        repeat (10) @(posedge clk_sys);
        chk_port();
        // Update bit without its byte lane is no strobe; low lane still stores
        be = 4'h1;
        wr_reg(IDX_LEFT_VOL, {23'h0, 3'b100, r[17:12]});
        be = 4'hF;
        chk_port();
        rd_chk(IDX_LEFT_VOL, {26'h0, r[17:12]});
        test_done();
    end
endmodule
`default_nettype wire
